//--- hw/dmcp_pkg.sv
/*
  Shared constants and types for the dual mode control port: both ends,
  link pin indices, address values, byte counts and state encodings.
  Assumes a 200 MHz system clock and a slower serial link clock.
*/
package dmcp_pkg;
  // ****************************************
  // Link framing
  // ****************************************
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [3:0] BIT_LAST        = 4'h7;
  localparam logic [7:0] I2C_BASE_BYTE   = 8'h04;
  localparam int         I2C_LO_BIT      = 5;
  localparam int         I2C_HI_BIT      = 6;
  localparam logic [6:0] SPI_CHIP_ADDR   = 7'h06;
  localparam logic [1:0] SPI_MODE_PULSES = 2'h3;
  localparam logic [1:0] BI_HDR          = 2'h0;
  localparam logic [1:0] BI_REG          = 2'h1;
  localparam logic [1:0] BI_DATA         = 2'h2;
  localparam logic [7:0] REG_RESET       = 8'h00;
  // ****************************************
  // Device pin sampler indices
  // ****************************************
  localparam int NPIN  = 9;
  localparam int P_SCK = 0;
  localparam int P_SDA = 1;
  localparam int P_SS  = 2;
  localparam int P_MOSI = 3;
  localparam int P_SA  = 4;
  localparam int P_ALO = 5;
  localparam int P_AHI = 6;
  localparam int P_SRST = 7;
  localparam int P_POR = 8;
  // ****************************************
  // Host timing
  // ****************************************
  localparam int CLK_NS  = 5;
  localparam int QTR_NS  = 320;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] Q0 = 2'h0;
  localparam logic [1:0] Q1 = 2'h1;
  localparam logic [1:0] Q2 = 2'h2;
  localparam logic [1:0] Q3 = 2'h3;
  localparam logic [2:0] IT_START = 3'h0;
  localparam logic [2:0] IT_BYTE  = 3'h1;
  localparam logic [2:0] IT_RBYTE = 3'h2;
  localparam logic [2:0] IT_STOP  = 3'h3;
  localparam logic [2:0] IT_SSL   = 3'h4;
  localparam logic [2:0] IT_SSH   = 3'h5;
  localparam logic [2:0] IT_END   = 3'h6;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    K_I2C_WR = 2'h0, K_I2C_RD = 2'h1, K_SPI_WR = 2'h2, K_SPI_RD = 2'h3
  } dmcp_kind_e;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_RX = 5'h02, ST_ACK = 5'h04,
    ST_TX   = 5'h08, ST_MACK = 5'h10
  } dmcp_dev_state_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'h1, HS_RUN = 2'h2
  } dmcp_host_state_e;
endpackage : dmcp_pkg

//--- hw/dmcp_if.sv
/*
  Link between host and device: serial clock, select, data pins.
  Assumes an external pull-up on the open-drain data line; the wire
  level is resolved here from both output enables.
*/
`timescale 1ns/1ps
interface dmcp_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic sda;
  logic miso;
  // Open drain: any enabled driver pulls low
  assign sda  = (host_sda_oe | dev_sda_oe) ? 1'b0 : 1'b1;
  // Shared line, undriven level reads low
  assign miso = dev_miso_oe ? dev_miso_o : 1'b0;
  modport host (output sck, ss_n, mosi, host_sda_o, host_sda_oe,
                input  sda, miso);
  modport device (input  sck, ss_n, mosi, sda,
                  output dev_sda_o, dev_sda_oe, dev_miso_o, dev_miso_oe);
endinterface : dmcp_if

//--- hw/dmcp_device.sv
/*
  Device end of the dual mode control port: I2C slave by default,
  SPI slave after three select pulses, with a small register file.
  Assumes link_clk_i oversamples the serial pins at least four times
  per serial quarter period; user side runs on clock_i.
*/
// How it works
// - Ack I2C address byte when it matches
// - Ack the register pointer byte
// - Ack data byte, stop ends write
// - Host reads via pointer write, repeated start
// - Drive selected register in byte after address
// - Start in I2C; three selects enter SPI
// - SPI access only after mode switch frames
// - SPI mode cleared only by power cycle
// - SPI frame: chip byte, register, data
// - Serial pins fully asynchronous, synchronised first
// - Chip address sits in upper seven bits
// - First byte LSB: one read, zero write
// - MISO driven only during read data bytes
// - Held select bursts sequential registers
// - Host inits by burst write then readback; dmcp_host writes one register per command
// - Standalone strap sampled at reset
// - I2C address from base plus two straps
`timescale 1ns/1ps
module dmcp_device
  import dmcp_pkg::*;
#(
  parameter int NUM_REGS = 16
) (
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       link_clk_i,
  input  wire logic       por_i,
  input  wire logic       standalone_strap_i,
  input  wire logic       i2c_addr_strap_low_i,
  input  wire logic       i2c_addr_strap_high_i,
  dmcp_if.device          lnk,
  output logic            reg_wr_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_data_o,
  output logic            spi_mode_o,
  output logic            standalone_o
);
  localparam int AW = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

  // ****************************************
  // Link domain pin sampling
  // ****************************************
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_s;
  logic [NPIN-1:0] pin_d;
  assign pin_raw = {por_i, srst_i, i2c_addr_strap_high_i,
                    i2c_addr_strap_low_i, standalone_strap_i,
                    lnk.mosi, lnk.ss_n, lnk.sda, lnk.sck};

  // Pins are unrelated to link_clk_i, two stages before use
  always_ff @(posedge link_clk_i) begin
    pin_meta <= pin_raw;
    pin_s    <= pin_meta;
    pin_d    <= pin_s;
  end

  logic por_rst;
  logic lrst;
  logic sck_rise;
  logic sck_fall;
  logic sda_fall;
  logic sda_rise;
  logic ss_rise;
  assign por_rst  = pin_s[P_POR];
  assign lrst     = pin_s[P_POR] | pin_s[P_SRST];
  assign sck_rise = pin_s[P_SCK] & ~pin_d[P_SCK];
  assign sck_fall = ~pin_s[P_SCK] & pin_d[P_SCK];
  assign sda_fall = ~pin_s[P_SDA] & pin_d[P_SDA];
  assign sda_rise = pin_s[P_SDA] & ~pin_d[P_SDA];
  assign ss_rise  = pin_s[P_SS] & ~pin_d[P_SS];

  // ****************************************
  // Mode control
  // ****************************************
  logic       spi_mode;
  logic [1:0] pulse_cnt;
  logic       standalone;

  // Soft reset leaves the mode alone; only power-on clears it
  always_ff @(posedge link_clk_i) begin
    if (por_rst) begin
      spi_mode  <= 1'b0;
      pulse_cnt <= 2'h0;
    // Switch at the end of the third pulse, so that frame stays a dummy
    end else if (!spi_mode && !standalone && ss_rise) begin
      if (pulse_cnt == SPI_MODE_PULSES - 2'h1) begin
        spi_mode <= 1'b1;
      end else begin
        pulse_cnt <= pulse_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      standalone <= pin_s[P_SA];
    end
  end

  logic [7:0] my_addr;
  always_comb begin
    my_addr             = I2C_BASE_BYTE;
    my_addr[I2C_HI_BIT] = pin_s[P_AHI];
    my_addr[I2C_LO_BIT] = pin_s[P_ALO];
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] regs [NUM_REGS];
  logic       wr_pend;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;
  logic       wr_tog;

  function automatic logic [7:0] rd(input logic [7:0] a);
    rd = (int'(a) < NUM_REGS) ? regs[a[AW-1:0]] : 8'h00;
  endfunction : rd

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (wr_pend && int'(wr_ptr) < NUM_REGS) begin
      regs[wr_ptr[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      wr_tog <= 1'b0;
    end else if (wr_pend) begin
      wr_tog <= ~wr_tog;
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  dmcp_dev_state_e state;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] ptr;
  logic       rw;
  logic       hit;
  logic       sda_oe;
  logic       miso;
  logic       miso_oe;
  logic [7:0] rx_next;
  logic [1:0] idx_next;
  assign rx_next  = {rx_sh[6:0], pin_s[P_MOSI]};
  assign idx_next = (byte_idx == BI_DATA) ? BI_DATA : byte_idx + 2'h1;
  logic [7:0] rd_new;
  logic [7:0] rd_cur;
  logic [7:0] rd_inc;
  // Process form, so register contents are in the sensitivity
  always_comb begin
    rd_new = rd(rx_next);
    rd_cur = rd(ptr);
    rd_inc = rd(ptr + 8'h01);
  end

  always_ff @(posedge link_clk_i) begin
    wr_pend <= 1'b0;
    if (lrst || standalone) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      byte_idx <= BI_HDR;
      rx_sh    <= 8'h00;
      tx_sh    <= 8'h00;
      ptr      <= 8'h00;
      rw       <= 1'b0;
      hit      <= 1'b0;
      sda_oe   <= 1'b0;
      miso     <= 1'b0;
      miso_oe  <= 1'b0;
      wr_ptr   <= 8'h00;
      wr_data  <= 8'h00;
    end else if (spi_mode) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
      if (pin_s[P_SS]) begin
        bit_cnt  <= 4'h0;
        byte_idx <= BI_HDR;
        miso_oe  <= 1'b0;
      end else begin
        if (sck_rise) begin
          rx_sh <= rx_next;
          if (bit_cnt == BIT_LAST) begin
            bit_cnt  <= 4'h0;
            byte_idx <= idx_next;
            if (byte_idx == BI_HDR) begin
              rw  <= pin_s[P_MOSI];
              hit <= (rx_sh[6:0] == SPI_CHIP_ADDR);
            end else if (byte_idx == BI_REG) begin
              ptr     <= rx_next;
              tx_sh   <= rd_new;
              miso    <= rd_new[7];
              miso_oe <= rw & hit;
            end else begin
              ptr <= ptr + 8'h01;
              if (hit && !rw) begin
                wr_pend <= 1'b1;
                wr_ptr  <= ptr;
                wr_data <= rx_next;
              end
              // Next MSB waits for the falling edge; host samples late
              tx_sh <= rd_inc;
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        if (sck_fall && byte_idx == BI_DATA) begin
          if (bit_cnt != 4'h0) begin
            tx_sh <= {tx_sh[6:0], 1'b0};
            miso  <= tx_sh[6];
          end else begin
            miso <= tx_sh[7];
          end
        end
      end
    end else begin
      miso_oe <= 1'b0;
      if (pin_s[P_SCK] && sda_fall) begin
        state    <= ST_RX;
        bit_cnt  <= 4'h0;
        byte_idx <= BI_HDR;
        sda_oe   <= 1'b0;
      end else if (pin_s[P_SCK] && sda_rise) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_RX: begin
            if (sck_rise) begin
              rx_sh   <= {rx_sh[6:0], pin_s[P_SDA]};
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (sck_fall && bit_cnt == BYTE_BITS) begin
              bit_cnt <= 4'h0;
              state   <= ST_ACK;
              sda_oe  <= 1'b1;
              if (byte_idx == BI_HDR) begin
                rw <= rx_sh[0];
                if (rx_sh[7:1] != my_addr[7:1]) begin
                  state  <= ST_IDLE;
                  sda_oe <= 1'b0;
                end
              end else if (byte_idx == BI_REG) begin
                ptr <= rx_sh;
              end else begin
                wr_pend <= 1'b1;
                wr_ptr  <= ptr;
                wr_data <= rx_sh;
                ptr     <= ptr + 8'h01;
              end
            end
          end
          ST_ACK: begin
            if (sck_fall) begin
              byte_idx <= idx_next;
              if (rw && byte_idx == BI_HDR) begin
                state  <= ST_TX;
                tx_sh  <= rd_cur;
                sda_oe <= ~rd_cur[7];
              end else begin
                state  <= ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (sck_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (sck_fall) begin
              if (bit_cnt == BYTE_BITS) begin
                state   <= ST_MACK;
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
              end else begin
                tx_sh  <= {tx_sh[6:0], 1'b0};
                sda_oe <= ~tx_sh[6];
              end
            end
          end
          ST_MACK: begin
            if (sck_rise) begin
              rx_sh <= {rx_sh[6:0], pin_s[P_SDA]};
            end
            if (sck_fall) begin
              if (!rx_sh[0]) begin
                ptr    <= ptr + 8'h01;
                state  <= ST_TX;
                tx_sh  <= rd_inc;
                sda_oe <= ~rd_inc[7];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    lnk.dev_sda_o   <= 1'b0;
    lnk.dev_sda_oe  <= sda_oe;
    lnk.dev_miso_o  <= miso;
    lnk.dev_miso_oe <= miso_oe;
  end

  // ****************************************
  // User domain crossing
  // ****************************************
  logic tog_meta;
  logic tog_s;
  logic tog_d;
  logic spi_meta;
  logic sa_meta;

  // Write bundle holds for many link cycles, toggle marks it valid
  always_ff @(posedge clock_i) begin
    tog_meta <= wr_tog;
    tog_s    <= tog_meta;
    // Not reset, so a soft reset cannot fake a write strobe
    tog_d    <= tog_s;
    spi_meta <= spi_mode;
    sa_meta  <= standalone;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reg_wr_o     <= 1'b0;
      reg_addr_o   <= 8'h00;
      reg_data_o   <= 8'h00;
      spi_mode_o   <= 1'b0;
      standalone_o <= 1'b0;
    end else begin
      reg_wr_o     <= tog_s ^ tog_d;
      spi_mode_o   <= spi_meta;
      standalone_o <= sa_meta;
      if (tog_s ^ tog_d) begin
        reg_addr_o <= wr_ptr;
        reg_data_o <= wr_data;
      end
    end
  end
endmodule : dmcp_device

//--- hw/dmcp_host.sv
/*
  Host end of the dual mode control port: plays one I2C or SPI
  register transaction per command, making the serial clock itself.
  Assumes clock_i at 200 MHz; one serial bit takes four quarters.
*/
`timescale 1ns/1ps
module dmcp_host
  import dmcp_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  dmcp_if.host            lnk,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire dmcp_kind_e cmd_kind_i,
  input  wire logic [1:0] cmd_straps_i,
  input  wire logic [7:0] cmd_reg_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            done_o,
  output logic            nack_o,
  output logic [7:0]      rdata_o
);
  // ****************************************
  // Transaction scripts
  // ****************************************
  dmcp_kind_e kind;
  logic [1:0] straps;
  logic [7:0] creg;
  logic [7:0] cdata;

  function automatic logic [2:0] item(input dmcp_kind_e k,
                                      input logic [2:0] i);
    item = IT_END;
    if (k == K_I2C_WR) begin
      if (i == 3'h0) item = IT_START;
      else if (i < 3'h4) item = IT_BYTE;
      else if (i == 3'h4) item = IT_STOP;
    end else if (k == K_I2C_RD) begin
      if (i == 3'h0 || i == 3'h3) item = IT_START;
      else if (i == 3'h5) item = IT_RBYTE;
      else if (i == 3'h6) item = IT_STOP;
      else if (i != 3'h7) item = IT_BYTE;
    end else begin
      if (i == 3'h0) item = IT_SSL;
      else if (i < 3'h4) item = IT_BYTE;
      else if (i == 3'h4) item = IT_SSH;
    end
  endfunction : item

  function automatic logic [7:0] bval(input logic [2:0] i);
    logic [7:0] a;
    a             = I2C_BASE_BYTE;
    a[I2C_HI_BIT] = straps[1];
    a[I2C_LO_BIT] = straps[0];
    bval          = cdata;
    if (kind == K_I2C_WR || kind == K_I2C_RD) begin
      if (i == 3'h1) bval = a;
      else if (i == 3'h2) bval = creg;
      else if (i == 3'h4) bval = a | 8'h01;
    end else begin
      if (i == 3'h1) bval = {SPI_CHIP_ADDR, kind == K_SPI_RD};
      else if (i == 3'h2) bval = creg;
    end
  endfunction : bval

  // ****************************************
  // Sequencer
  // ****************************************
  dmcp_host_state_e state;
  logic [15:0] qcnt;
  logic [1:0]  q;
  logic [2:0]  idx;
  logic [3:0]  bitn;
  logic [7:0]  sh;
  logic [7:0]  rsh;
  logic        sda_meta;
  logic        sda_s;
  logic        miso_meta;
  logic        miso_s;
  logic        is_spi;
  logic [2:0]  it;
  logic [3:0]  last_bit;
  assign is_spi   = (kind == K_SPI_WR) || (kind == K_SPI_RD);
  assign it       = item(kind, idx);
  assign last_bit = is_spi ? BIT_LAST : BYTE_BITS;

  always_ff @(posedge clock_i) begin
    sda_meta  <= lnk.sda;
    sda_s     <= sda_meta;
    miso_meta <= lnk.miso;
    miso_s    <= miso_meta;
  end

  always_ff @(posedge clock_i) begin
    done_o <= 1'b0;
    if (srst_i) begin
      state           <= HS_IDLE;
      cmd_ready_o     <= 1'b0;
      nack_o          <= 1'b0;
      rdata_o         <= 8'h00;
      kind            <= K_I2C_WR;
      straps          <= 2'h0;
      creg            <= 8'h00;
      cdata           <= 8'h00;
      qcnt            <= 16'h0000;
      q               <= Q0;
      idx             <= 3'h0;
      bitn            <= 4'h0;
      sh              <= 8'h00;
      rsh             <= 8'h00;
      lnk.sck         <= 1'b1;
      lnk.ss_n        <= 1'b1;
      lnk.mosi        <= 1'b0;
      lnk.host_sda_o  <= 1'b0;
      lnk.host_sda_oe <= 1'b0;
    end else begin
      case (state)
        HS_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            state       <= HS_RUN;
            cmd_ready_o <= 1'b0;
            kind        <= cmd_kind_i;
            straps      <= cmd_straps_i;
            creg        <= cmd_reg_i;
            cdata       <= cmd_data_i;
            nack_o      <= 1'b0;
            qcnt        <= 16'h0000;
            q           <= Q0;
            idx         <= 3'h0;
            bitn        <= 4'h0;
          end
        end
        HS_RUN: begin
          if (qcnt != 16'(QTR - 1)) begin
            qcnt <= qcnt + 16'h0001;
          end else begin
            qcnt <= 16'h0000;
            q    <= q + 2'h1;
            case (it)
              IT_START: begin
                if (q == Q0) lnk.host_sda_oe <= 1'b0;
                if (q == Q0) lnk.sck <= 1'b0;
                if (q == Q1) lnk.sck <= 1'b1;
                if (q == Q2) lnk.host_sda_oe <= 1'b1;
                if (q == Q3) lnk.sck <= 1'b0;
              end
              IT_STOP: begin
                if (q == Q0) lnk.host_sda_oe <= 1'b1;
                if (q == Q1) lnk.sck <= 1'b1;
                if (q == Q2) lnk.host_sda_oe <= 1'b0;
              end
              IT_SSL: begin
                if (q == Q0) lnk.ss_n <= 1'b0;
                if (q == Q0) lnk.sck <= 1'b0;
              end
              IT_SSH: begin
                if (q == Q0) lnk.ss_n <= 1'b1;
              end
              IT_BYTE, IT_RBYTE: begin
                if (q == Q0) begin
                  lnk.sck  <= 1'b0;
                  lnk.mosi <= sh[7];
                  lnk.host_sda_oe <= !is_spi && it == IT_BYTE &&
                                     bitn != BYTE_BITS && !sh[7];
                end
                if (q == Q1) lnk.sck <= 1'b1;
                if (q == Q2) begin
                  if (bitn != BYTE_BITS) begin
                    rsh <= {rsh[6:0], is_spi ? miso_s : sda_s};
                  end else if (it == IT_BYTE && sda_s) begin
                    nack_o <= 1'b1;
                  end
                end
                if (q == Q3) begin
                  lnk.sck <= 1'b0;
                  sh      <= {sh[6:0], 1'b0};
                  bitn    <= bitn + 4'h1;
                end
              end
              default: begin
                state   <= HS_IDLE;
                done_o  <= 1'b1;
                rdata_o <= rsh;
              end
            endcase
            if (q == Q3 && (it != IT_BYTE && it != IT_RBYTE ||
                            bitn == last_bit)) begin
              idx  <= idx + 3'h1;
              bitn <= 4'h0;
              sh   <= bval(idx + 3'h1);
            end
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end
endmodule : dmcp_host

//--- bench/dmcp_link_monitor.sv
/*
  Checker for the link between host and device ends.
  Assumes plain interface signals and the device link clock.
*/
`timescale 1ns/1ps
module dmcp_link_monitor (
  input wire logic link_clk_i,
  input wire logic srst_i,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_miso_o,
  input wire logic dev_miso_oe
);
  // ********
  // Link rules
  // ********
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (srst_i);
  ack_low_a: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("sda driven high");
  ack_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
    else $error("sda pull too short");
  sda_move_a: assert property ($changed(dev_sda_oe) |-> !sck)
    else $error("sda moved while clock high");
  sda_i2c_a: assert property ($rose(dev_sda_oe) |-> ss_n)
    else $error("sda driven in a frame");
  pin_excl_a: assert property (dev_miso_oe |-> !dev_sda_oe)
    else $error("both data pins driven");
  miso_rel_a: assert property ($rose(ss_n) |-> ##[0:8] !dev_miso_oe)
    else $error("miso held after frame");
  miso_byte_a: assert property ($rose(dev_miso_oe) |-> dev_miso_oe[*8])
    else $error("miso drive too short");
  miso_hold_a: assert property (
    dev_miso_oe && $past(dev_miso_oe) && sck && $past(sck)
    |-> $stable(dev_miso_o))
    else $error("miso moved while clock high");
  cover property ($rose(dev_sda_oe));
  cover property ($rose(dev_miso_oe));
  cover property ($fell(ss_n));
endmodule : dmcp_link_monitor

//--- bench/tb.sv
/*
  Self-checking bench: host and device joined by the link.
  Assumes the package, interface, both ends and checker compiled.
*/
`timescale 1ns/1ps
module tb;
  import dmcp_pkg::*;
  logic       clock_i      = 1'b0;
  logic       link_clk_i   = 1'b0;
  logic       srst_i       = 1'b1;
  logic       por_i        = 1'b1;
  logic       cmd_valid_i  = 1'b0;
  dmcp_kind_e cmd_kind_i   = K_I2C_WR;
  logic [1:0] cmd_straps_i = 2'h0;
  logic [7:0] cmd_reg_i    = 8'h00;
  logic [7:0] cmd_data_i   = 8'h00;
  logic [7:0] wr_cnt       = 8'h00;
  logic       standalone_strap_i = 1'b0;
  logic       cmd_ready_o, done_o, nack_o, reg_wr_o, spi_mode_o;
  logic       standalone_o;
  logic [7:0] rdata_o, reg_addr_o, reg_data_o;
  int         failures     = 0;
  int         n_compared   = 0;
  // ********
  // Clocks and ends
  // ********
  always #2.5 clock_i = ~clock_i;
  // Offset keeps link edges off the system clock edges
  initial begin
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  always @(posedge clock_i) begin
    if (reg_wr_o === 1'b1) begin
      wr_cnt <= wr_cnt + 8'h01;
    end
  end
  dmcp_if dmcp_if_i ();
  dmcp_host #(.QTR(32)) dmcp_host_i (.clock_i, .srst_i,
    .lnk(dmcp_if_i), .cmd_valid_i, .cmd_ready_o, .cmd_kind_i,
    .cmd_straps_i, .cmd_reg_i, .cmd_data_i, .done_o, .nack_o, .rdata_o);
  dmcp_device #(.NUM_REGS(16)) dmcp_device_i (.clock_i, .srst_i,
    .link_clk_i, .por_i, .standalone_strap_i,
    .i2c_addr_strap_low_i(1'b0), .i2c_addr_strap_high_i(1'b1),
    .lnk(dmcp_if_i), .reg_wr_o, .reg_addr_o, .reg_data_o,
    .spi_mode_o, .standalone_o);
  dmcp_link_monitor dmcp_link_monitor_i (.link_clk_i, .srst_i,
    .sck(dmcp_if_i.sck), .ss_n(dmcp_if_i.ss_n),
    .dev_sda_o(dmcp_if_i.dev_sda_o), .dev_sda_oe(dmcp_if_i.dev_sda_oe),
    .dev_miso_o(dmcp_if_i.dev_miso_o),
    .dev_miso_oe(dmcp_if_i.dev_miso_oe));
  // ********
  // Shared tasks
  // ********
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // Bounded wait on ready (0) or done (1); a hang ends the run
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while ((w ? done_o : cmd_ready_o) !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      failures++;
      summarize();
    end
  endtask : wait_hi
  task automatic cmd(input dmcp_kind_e k, input logic [1:0] s,
                     input logic [7:0] r, d);
    cmd_kind_i   <= k;
    cmd_straps_i <= s;
    cmd_reg_i    <= r;
    cmd_data_i   <= d;
    cmd_valid_i  <= 1'b1;
    wait_hi(0);
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    wait_hi(1);
    @(posedge clock_i);
  endtask : cmd
  // ********
  // Scenarios
  // ********
  task automatic t_i2c();
    cmd(K_I2C_WR, 2'h2, 8'h05, 8'hA5);
    chk("nack", {7'h00, nack_o}, 8'h00);
    chk("wr_cnt", wr_cnt, 8'h01);
    chk("wr_addr", reg_addr_o, 8'h05);
    chk("wr_data", reg_data_o, 8'hA5);
    cmd(K_I2C_RD, 2'h2, 8'h05, 8'h00);
    chk("rdata", rdata_o, 8'hA5);
    // Wrong straps address another device
    cmd(K_I2C_WR, 2'h1, 8'h05, 8'h00);
    chk("nack", {7'h00, nack_o}, 8'h01);
    chk("wr_cnt", wr_cnt, 8'h01);
  endtask : t_i2c
  task automatic t_spi_enter();
    for (int i = 0; i < 3; i++) begin
      chk("spi_mode", {7'h00, spi_mode_o}, 8'h00);
      cmd(K_SPI_WR, 2'h0, 8'h07, 8'h77);
    end
    chk("spi_mode", {7'h00, spi_mode_o}, 8'h01);
    chk("wr_cnt", wr_cnt, 8'h01);
  endtask : t_spi_enter
  task automatic t_spi();
    cmd(K_SPI_WR, 2'h0, 8'h03, 8'h5A);
    chk("wr_cnt", wr_cnt, 8'h02);
    chk("wr_addr", reg_addr_o, 8'h03);
    chk("wr_data", reg_data_o, 8'h5A);
    cmd(K_SPI_RD, 2'h0, 8'h03, 8'h00);
    chk("rdata", rdata_o, 8'h5A);
    cmd(K_SPI_RD, 2'h0, 8'h05, 8'h00);
    chk("rdata", rdata_o, 8'hA5);
    cmd(K_SPI_RD, 2'h0, 8'h07, 8'h00);
    chk("rdata", rdata_o, 8'h00);
  endtask : t_spi
  task automatic t_soft();
    standalone_strap_i <= 1'b1;
    srst_i             <= 1'b1;
    repeat (40) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    chk("standalone", {7'h00, standalone_o}, 8'h01);
    cmd(K_SPI_WR, 2'h0, 8'h03, 8'h33);
    chk("wr_cnt", wr_cnt, 8'h02);
    standalone_strap_i <= 1'b0;
    srst_i             <= 1'b1;
    repeat (40) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    chk("standalone", {7'h00, standalone_o}, 8'h00);
    chk("spi_mode", {7'h00, spi_mode_o}, 8'h01);
    cmd(K_SPI_RD, 2'h0, 8'h03, 8'h00);
    chk("rdata", rdata_o, 8'h00);
    cmd(K_I2C_WR, 2'h2, 8'h05, 8'h11);
    chk("wr_cnt", wr_cnt, 8'h02);
  endtask : t_soft
  // Reset spans several link cycles so the link side sees it
  initial begin
    repeat (40) @(posedge clock_i);
    srst_i <= 1'b0;
    por_i  <= 1'b0;
    repeat (20) @(posedge clock_i);
    t_i2c();
    t_spi_enter();
    t_spi();
    t_soft();
    summarize();
  end
endmodule : tb
